//--- sicr_pkg.sv
// static address configuration register bank: shared constants and types
// assumes a 32-bit apb slave, word addressed by register index
package sicr_pkg;

	// ---------------------------------------------------------------
	// register indexes (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam int NUM_OCT = 13;
	localparam int IDX_W = 14;
	localparam logic [13:0] IDX_IP_MSB = 14'h03e5;
	localparam logic [13:0] IDX_IP_SECOND = 14'h03e6;
	localparam logic [13:0] IDX_IP_THIRD = 14'h03e7;
	localparam logic [13:0] IDX_IP_LSB = 14'h03e8;
	localparam logic [13:0] IDX_MASK_MSB = 14'h03e9;
	localparam logic [13:0] IDX_MASK_SECOND = 14'h03ea;
	localparam logic [13:0] IDX_MASK_THIRD = 14'h03eb;
	localparam logic [13:0] IDX_MASK_LSB = 14'h03ec;
	localparam logic [13:0] IDX_GW_MSB = 14'h03ed;
	localparam logic [13:0] IDX_GW_SECOND = 14'h03ee;
	localparam logic [13:0] IDX_GW_THIRD = 14'h03ef;
	localparam logic [13:0] IDX_GW_LSB = 14'h03f0;
	localparam logic [13:0] IDX_STARTUP_MODE = 14'h03f1;
	localparam logic [13:0] IDX_RELOAD_CMD = 14'h0b5b;
	localparam logic [13:0] IDX_RELOAD_STATUS = 14'h0b5c;

	// slot order of the octet store: ip, mask, gateway, startup mode
	localparam logic [13:0] OCT_IDX [NUM_OCT] = '{
		IDX_IP_MSB, IDX_IP_SECOND, IDX_IP_THIRD, IDX_IP_LSB,
		IDX_MASK_MSB, IDX_MASK_SECOND, IDX_MASK_THIRD, IDX_MASK_LSB,
		IDX_GW_MSB, IDX_GW_SECOND, IDX_GW_THIRD, IDX_GW_LSB,
		IDX_STARTUP_MODE
	};
	localparam int SLOT_MODE = 12;

	// ---------------------------------------------------------------
	// values after reset
	// ---------------------------------------------------------------
	localparam logic [7:0] OCT_RST [NUM_OCT] = '{
		8'hc0, 8'ha8, 8'h01, 8'h14,
		8'hff, 8'hff, 8'hff, 8'h00,
		8'hc0, 8'ha8, 8'h01, 8'h01,
		8'h02
	};

	// reload command codes
	localparam logic [7:0] CMD_IDLE = 8'h00;
	localparam logic [7:0] CMD_RELOAD_NOW = 8'h01;
	localparam logic [7:0] CMD_CANCEL = 8'h02;

	// status register fields
	localparam int ST_REQ_BIT = 0;
	localparam int ST_STATIC_BIT = 1;
	localparam int ST_DIFF_BIT = 2;

	typedef enum logic [1:0] {
		SICR_MODE_STATIC = 2'b00,
		SICR_MODE_BOOTP = 2'b01,
		SICR_MODE_DHCP = 2'b10
	} sicr_mode_t;

	typedef struct packed {
		logic [3:0][7:0] ip;
		logic [3:0][7:0] mask;
		logic [3:0][7:0] gw;
		sicr_mode_t mode;
	} sicr_net_cfg_t;

endpackage : sicr_pkg

//--- sicr_cfg_byte.sv
// one configuration octet: pending copy written by software, active copy
// assumes apply is a one-cycle pulse from the reload logic
`timescale 1ns/100ps

module sicr_cfg_byte #(
	parameter logic [7:0] RESET_VAL = 8'h00
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [7:0] wdata,
	input wire logic apply,
	output logic [7:0] pending,
	output logic [7:0] active
);

	logic [7:0] pending_reg;
	logic [7:0] active_reg;

	// apply takes the old pending value, so a write in the same cycle waits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending_reg <= RESET_VAL;
			active_reg <= RESET_VAL;
		end else begin
			if (wr_en) begin
				pending_reg <= wdata;
			end
			if (apply) begin
				active_reg <= pending_reg;
			end
		end
	end

	assign pending = pending_reg;
	assign active = active_reg;

endmodule : sicr_cfg_byte

//--- sicr_apb_port.sv
// apb slave front end: decode, zero-wait answer, registered read data
// assumes the master keeps the request stable through the access phase
`timescale 1ns/100ps

module sicr_apb_port #(
	parameter int ADDR_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic hit,
	input wire logic [31:0] rd_value,
	output logic [sicr_pkg::IDX_W-1:0] idx,
	output logic wr_stb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	if (ADDR_W < sicr_pkg::IDX_W + 2) begin : g_check
		$error("sicr_apb_port: ADDR_W too small for the register map");
	end

	logic [31:0] prdata_reg;
	wire setup_ph = psel & ~penable;
	wire access_ph = psel & penable;
	wire aligned = (paddr[1:0] == 2'b00);
	// shift, not slice: at the default width nothing lies above the index field
	wire upper_zero = ((paddr >> (sicr_pkg::IDX_W + 2)) == '0);
	wire mapped = hit & aligned & upper_zero;

	assign idx = paddr[sicr_pkg::IDX_W+1:2];
	assign pready = access_ph;
	assign pslverr = access_ph & ~mapped;
	assign wr_stb = access_ph & pwrite & mapped;
	assign prdata = prdata_reg;

	// read data caught in setup so that it comes from a flop with no wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (setup_ph) begin
			prdata_reg <= (mapped & ~pwrite) ? rd_value : 32'h0000_0000;
		end
	end

endmodule : sicr_apb_port

//--- sicr_regs.sv
// static address configuration register bank, apb slave, top level
// assumes a single 40 mhz clock and that net_busy is synchronous to it
//
// What this block does
// - code 1 applies pending changes at once, or once net_busy drops
// - code 2 cancels an outstanding reload request
// - command register returns to zero by itself
// - static values used only in static mode
// - new values wait for reload; power-up restores the defaults
// - ip octets default 192.168.1.20
// - mask octets default 255.255.255.0
// - gateway msb octet defaults to 192
// - startup mode: static, bootp, dhcp; dhcp default
// - gateway lower octets default 168, 1, 1
//
// Local design decision: register access over APB.
`timescale 1ns/100ps

module sicr_regs #(
	parameter int ADDR_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic net_busy,
	output sicr_pkg::sicr_net_cfg_t active_cfg,
	output logic use_static,
	output logic [31:0] static_ip,
	output logic [31:0] static_mask,
	output logic [31:0] static_gw,
	output logic reload_applied
);

	// ---------------------------------------------------------------
	// bus front end
	// ---------------------------------------------------------------
	logic [sicr_pkg::IDX_W-1:0] idx;
	logic wr_stb;
	logic [31:0] rd_value;
	logic [sicr_pkg::NUM_OCT-1:0] hit_oct;
	logic [7:0] pend [sicr_pkg::NUM_OCT];
	logic [7:0] act [sicr_pkg::NUM_OCT];

	wire hit_cmd = (idx == sicr_pkg::IDX_RELOAD_CMD);
	wire hit_status = (idx == sicr_pkg::IDX_RELOAD_STATUS);
	wire hit_any = (|hit_oct) | hit_cmd | hit_status;

	sicr_apb_port #(
		.ADDR_W(ADDR_W)
	) u_port (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.hit(hit_any),
		.rd_value(rd_value),
		.idx(idx),
		.wr_stb(wr_stb),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr)
	);

	// ---------------------------------------------------------------
	// reload command and request
	// ---------------------------------------------------------------
	logic [7:0] cmd_reg;
	logic [7:0] cmd_next;
	logic req_reg;
	logic req_next;
	logic applied_reg;

	wire [7:0] wbyte = pwdata[7:0];
	wire cmd_wr = wr_stb & hit_cmd;
	wire cmd_ok = (pwdata[31:8] == 24'h00_0000)
		& ((wbyte == sicr_pkg::CMD_RELOAD_NOW) | (wbyte == sicr_pkg::CMD_CANCEL));
	wire set_reload = cmd_wr & cmd_ok & (wbyte == sicr_pkg::CMD_RELOAD_NOW);
	wire cancel_reload = cmd_wr & cmd_ok & (wbyte == sicr_pkg::CMD_CANCEL);
	// copy is held off while the network side is mid-transaction
	wire apply = req_reg & ~net_busy;

	// accepted code shows for one cycle, then the register falls back to 0
	assign cmd_next = (cmd_wr & cmd_ok) ? wbyte : sicr_pkg::CMD_IDLE;
	// a new reload request wins over the clear by apply or cancel
	assign req_next = set_reload ? 1'b1
		: (cancel_reload | apply) ? 1'b0
		: req_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_reg <= sicr_pkg::CMD_IDLE;
			req_reg <= 1'b0;
			applied_reg <= 1'b0;
		end else begin
			cmd_reg <= cmd_next;
			req_reg <= req_next;
			applied_reg <= apply;
		end
	end

	// ---------------------------------------------------------------
	// octet store: pending and active copies
	// ---------------------------------------------------------------
	wire mode_ok = (pwdata[31:2] == 30'h0000_0000) & (pwdata[1:0] != 2'b11);

	for (genvar i = 0; i < sicr_pkg::NUM_OCT; i++) begin : g_oct
		wire val_ok = (i == sicr_pkg::SLOT_MODE) ? mode_ok : (pwdata[31:8] == 24'h00_0000);
		assign hit_oct[i] = (idx == sicr_pkg::OCT_IDX[i]);
		sicr_cfg_byte #(
			.RESET_VAL(sicr_pkg::OCT_RST[i])
		) u_byte (
			.pclk(pclk),
			.presetn(presetn),
			.wr_en(wr_stb & hit_oct[i] & val_ok),
			.wdata(wbyte),
			.apply(apply),
			.pending(pend[i]),
			.active(act[i])
		);
	end

	// ---------------------------------------------------------------
	// read mux and status
	// ---------------------------------------------------------------
	logic diff;
	logic [7:0] oct_rd;

	always_comb begin
		diff = 1'b0;
		oct_rd = 8'h00;
		for (int i = 0; i < sicr_pkg::NUM_OCT; i++) begin
			diff = diff | (pend[i] != act[i]);
			oct_rd = oct_rd | (hit_oct[i] ? pend[i] : 8'h00);
		end
	end

	wire [31:0] status_word = {29'h0000_0000, diff, use_static, req_reg};
	assign rd_value = hit_cmd ? {24'h00_0000, cmd_reg}
		: hit_status ? status_word
		: {24'h00_0000, oct_rd};

	// ---------------------------------------------------------------
	// active set towards the network logic
	// ---------------------------------------------------------------
	assign active_cfg.ip = {act[0], act[1], act[2], act[3]};
	assign active_cfg.mask = {act[4], act[5], act[6], act[7]};
	assign active_cfg.gw = {act[8], act[9], act[10], act[11]};
	assign active_cfg.mode = sicr_pkg::sicr_mode_t'(act[sicr_pkg::SLOT_MODE][1:0]);
	// outside static mode the static values are hidden, not merely flagged
	assign use_static = (active_cfg.mode == sicr_pkg::SICR_MODE_STATIC);
	assign static_ip = use_static ? active_cfg.ip : 32'h0000_0000;
	assign static_mask = use_static ? active_cfg.mask : 32'h0000_0000;
	assign static_gw = use_static ? active_cfg.gw : 32'h0000_0000;
	assign reload_applied = applied_reg;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	logic fresh_reg;
	logic [8*sicr_pkg::NUM_OCT-1:0] pend_flat;
	logic [8*sicr_pkg::NUM_OCT-1:0] act_flat;

	always_comb begin
		pend_flat = '0;
		act_flat = '0;
		for (int i = 0; i < sicr_pkg::NUM_OCT; i++) begin
			pend_flat[8*i +: 8] = pend[i];
			act_flat[8*i +: 8] = act[i];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fresh_reg <= 1'b1;
		end else begin
			fresh_reg <= 1'b0;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_reload_now;
		set_reload |=> req_reg ##0 (net_busy or (##1 act_flat == $past(pend_flat) && reload_applied));
	endproperty
	a_reload_now: assert property (p_reload_now) else $error("reload now not applied");

	property p_cancel;
		cancel_reload && !set_reload |=> !req_reg ##1 act_flat == $past(act_flat);
	endproperty
	a_cancel: assert property (p_cancel) else $error("cancel left a reload outstanding");

	property p_cmd_selfclear;
		cmd_wr && cmd_ok |=> cmd_reg == $past(wbyte) ##1 cmd_reg == sicr_pkg::CMD_IDLE;
	endproperty
	a_cmd_selfclear: assert property (p_cmd_selfclear) else $error("command register did not clear");

	property p_static_only;
		!use_static |-> static_ip == 32'h0000_0000 && static_mask == 32'h0000_0000
			&& static_gw == 32'h0000_0000;
	endproperty
	a_static_only: assert property (p_static_only) else $error("static values used outside static mode");

	property p_hold_active;
		!apply |=> act_flat == $past(act_flat) && !reload_applied;
	endproperty
	a_hold_active: assert property (p_hold_active) else $error("active set changed without reload");

	property p_ip_default;
		fresh_reg |-> active_cfg.ip == 32'hc0a8_0114;
	endproperty
	a_ip_default: assert property (p_ip_default) else $error("ip default wrong");

	property p_mask_default;
		fresh_reg |-> active_cfg.mask == 32'hffff_ff00;
	endproperty
	a_mask_default: assert property (p_mask_default) else $error("mask default wrong");

	property p_gw_msb_default;
		fresh_reg |-> active_cfg.gw[3] == 8'hc0;
	endproperty
	a_gw_msb_default: assert property (p_gw_msb_default) else $error("gateway msb default wrong");

	property p_mode_default;
		fresh_reg |-> active_cfg.mode == sicr_pkg::SICR_MODE_DHCP && !use_static;
	endproperty
	a_mode_default: assert property (p_mode_default) else $error("startup mode default wrong");

	property p_gw_low_default;
		fresh_reg |-> active_cfg.gw[2:0] == 24'ha8_0101;
	endproperty
	a_gw_low_default: assert property (p_gw_low_default) else $error("gateway low defaults wrong");

	property p_pending_first;
		wr_stb && hit_oct[0] && !apply && pwdata[31:8] == 24'h00_0000
			|=> pend[0] == $past(wbyte) && act[0] == $past(act[0]);
	endproperty
	a_pending_first: assert property (p_pending_first) else $error("write bypassed pending copy");

	// ---------------------------------------------------------------
	// refusals and request bookkeeping
	// ---------------------------------------------------------------
	property p_cmd_refused;
		cmd_wr && !cmd_ok && !apply |=> cmd_reg == sicr_pkg::CMD_IDLE && req_reg == $past(req_reg);
	endproperty
	a_cmd_refused: assert property (p_cmd_refused) else $error("refused command code was taken");

	property p_req_source;
		!req_reg && !set_reload |=> !req_reg;
	endproperty
	a_req_source: assert property (p_req_source) else $error("reload request raised without a command");

	property p_apply_clears;
		apply && !set_reload |=> !req_reg && reload_applied;
	endproperty
	a_apply_clears: assert property (p_apply_clears) else $error("copy did not retire the request");

	property p_busy_holds;
		req_reg && net_busy && !cancel_reload |=> req_reg && !reload_applied;
	endproperty
	a_busy_holds: assert property (p_busy_holds) else $error("reload taken while network busy");

	property p_mode_refused;
		wr_stb && hit_oct[sicr_pkg::SLOT_MODE] && !mode_ok
			|=> pend[sicr_pkg::SLOT_MODE] == $past(pend[sicr_pkg::SLOT_MODE]);
	endproperty
	a_mode_refused: assert property (p_mode_refused) else $error("illegal startup mode was stored");

	property p_mode_legal;
		pend[sicr_pkg::SLOT_MODE] <= 8'h02 && act[sicr_pkg::SLOT_MODE] <= 8'h02;
	endproperty
	a_mode_legal: assert property (p_mode_legal) else $error("startup mode holds an unused code");

	property p_static_values;
		use_static |-> static_ip == active_cfg.ip && static_mask == active_cfg.mask
			&& static_gw == active_cfg.gw;
	endproperty
	a_static_values: assert property (p_static_values) else $error("static values differ from active set");

	property p_clean_after_apply;
		apply && !(wr_stb && (|hit_oct)) |=> !diff;
	endproperty
	a_clean_after_apply: assert property (p_clean_after_apply) else $error("pending differs after copy");

	property p_no_write_on_error;
		pslverr |-> !wr_stb;
	endproperty
	a_no_write_on_error: assert property (p_no_write_on_error) else $error("write strobe on error response");

	c_reload: cover property (set_reload ##[1:20] reload_applied);
	c_cancel: cover property (set_reload ##1 net_busy ##[1:20] cancel_reload);
	c_refused: cover property (cmd_wr && !cmd_ok);
	c_static: cover property (applied_reg && use_static);
	c_unmapped: cover property (pslverr);

endmodule : sicr_regs

//--- sicr_regs_bench.sv
// self-checking testbench for the static address configuration register bank
// assumes the bank answers every apb transfer; drives all inputs at the rising edge
`timescale 1ns/100ps

module sicr_regs_bench;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic net_busy;
	logic [15:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic use_static;
	logic reload_applied;
	logic [31:0] static_ip;
	logic [31:0] static_mask;
	logic [31:0] static_gw;
	logic [31:0] rd;
	logic err;
	sicr_pkg::sicr_net_cfg_t active_cfg;
	int error_cnt;
	int compares;
	int p;
	logic [7:0] rst_val [13] = '{8'hc0, 8'ha8, 8'h01, 8'h14, 8'hff, 8'hff, 8'hff, 8'h00,
		8'hc0, 8'ha8, 8'h01, 8'h01, 8'h02};
	logic [7:0] new_ip [4] = '{8'h0a, 8'h00, 8'h00, 8'h05};

	sicr_regs sicr_regs_i (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.net_busy(net_busy),
		.active_cfg(active_cfg),
		.use_static(use_static),
		.static_ip(static_ip),
		.static_mask(static_mask),
		.static_gw(static_gw),
		.reload_applied(reload_applied)
	);

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// ---------------------------------------------------------------
	// bus tasks and comparison
	// ---------------------------------------------------------------
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// called just after a rising edge; returns just after one
	task xfer(input logic wr, input logic [13:0] idx, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no limit here: the watchdog ends a transfer that never completes
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer

	// flags sampled on the falling edge, clear of the launching edge
	task count_pulses();
		p = 0;
		repeat (8) begin
			@(negedge pclk);
			if (reload_applied === 1'b1) p++;
		end
		@(posedge pclk);
	endtask : count_pulses

	task test_done();
		$display("comparisons %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : test_done

	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h0000_0000;
		net_busy = 1'b0;
		error_cnt = 0;
		compares = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int k = 0; k < 13; k++) begin
			xfer(1'b0, sicr_pkg::OCT_IDX[k], 32'h0000_0000);
			chk("octet reset", 32'(rst_val[k]), rd);
		end
		chk("active ip", 32'hc0a8_0114, active_cfg.ip);
		chk("active mask", 32'hffff_ff00, active_cfg.mask);
		chk("active gw", 32'hc0a8_0101, active_cfg.gw);
		chk("use static", 32'h0000_0000, 32'(use_static));
		$display("test reset values done");

		// pending copy only; unmapped index answers with an error
		for (int k = 0; k < 4; k++) xfer(1'b1, sicr_pkg::OCT_IDX[k], 32'(new_ip[k]));
		for (int k = 0; k < 4; k++) begin
			xfer(1'b0, sicr_pkg::OCT_IDX[k], 32'h0000_0000);
			chk("pending ip", 32'(new_ip[k]), rd);
		end
		chk("active ip held", 32'hc0a8_0114, active_cfg.ip);
		xfer(1'b0, 14'h0100, 32'h0000_0000);
		chk("unmapped error", 32'h0000_0001, 32'(err));
		chk("unmapped data", 32'h0000_0000, rd);
		$display("test pending writes done");

		// every startup mode, each applied by reload now
		for (int m = 0; m < 3; m++) begin
			xfer(1'b1, sicr_pkg::IDX_STARTUP_MODE, 32'(m));
			xfer(1'b1, sicr_pkg::IDX_RELOAD_CMD, 32'h0000_0001);
			count_pulses();
			chk("reload pulses", 32'h0000_0001, 32'(p));
			chk("active ip", 32'h0a00_0005, active_cfg.ip);
			chk("active mode", 32'(m), 32'(active_cfg.mode));
			chk("use static", 32'(m == 0), 32'(use_static));
			chk("static ip", (m == 0) ? 32'h0a00_0005 : 32'h0000_0000, static_ip);
			chk("static mask", (m == 0) ? 32'hffff_ff00 : 32'h0000_0000, static_mask);
			chk("static gw", (m == 0) ? 32'hc0a8_0101 : 32'h0000_0000, static_gw);
			xfer(1'b0, sicr_pkg::IDX_RELOAD_CMD, 32'h0000_0000);
			chk("command cleared", 32'h0000_0000, rd);
		end
		$display("test reload modes done");

		// busy network holds the request, so cancel has one to drop
		xfer(1'b1, sicr_pkg::IDX_IP_LSB, 32'h0000_0007);
		net_busy <= 1'b1;
		xfer(1'b1, sicr_pkg::IDX_RELOAD_CMD, 32'h0000_0001);
		xfer(1'b0, sicr_pkg::IDX_RELOAD_STATUS, 32'h0000_0000);
		chk("request held", 32'h0000_0001, 32'(rd[sicr_pkg::ST_REQ_BIT]));
		chk("status held", 32'h0000_0005, rd);
		xfer(1'b1, sicr_pkg::IDX_RELOAD_CMD, 32'h0000_0002);
		xfer(1'b0, sicr_pkg::IDX_RELOAD_STATUS, 32'h0000_0000);
		chk("request dropped", 32'h0000_0000, 32'(rd[sicr_pkg::ST_REQ_BIT]));
		chk("status dropped", 32'h0000_0004, rd);
		net_busy <= 1'b0;
		count_pulses();
		chk("no copy", 32'h0000_0000, 32'(p));
		chk("active ip kept", 32'h0a00_0005, active_cfg.ip);
		xfer(1'b0, sicr_pkg::IDX_RELOAD_CMD, 32'h0000_0000);
		chk("command cleared", 32'h0000_0000, rd);
		$display("test cancel done");

		// refused codes leave command, request and mode untouched
		xfer(1'b1, sicr_pkg::IDX_RELOAD_CMD, 32'h0000_0003);
		xfer(1'b0, sicr_pkg::IDX_RELOAD_CMD, 32'h0000_0000);
		chk("refused command", 32'h0000_0000, rd);
		xfer(1'b1, sicr_pkg::IDX_STARTUP_MODE, 32'h0000_0003);
		xfer(1'b0, sicr_pkg::IDX_STARTUP_MODE, 32'h0000_0000);
		chk("refused mode", 32'h0000_0002, rd);
		xfer(1'b0, sicr_pkg::IDX_RELOAD_STATUS, 32'h0000_0000);
		chk("status after refusals", 32'h0000_0004, rd);
		$display("test refused codes done");

		// power-up again in mid-run brings the defaults back
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("ip after reset", 32'hc0a8_0114, active_cfg.ip);
		chk("mode after reset", 32'h0000_0002, 32'(active_cfg.mode));
		xfer(1'b0, sicr_pkg::IDX_IP_LSB, 32'h0000_0000);
		chk("pending ip after reset", 32'h0000_0014, rd);
		$display("test second reset done");
		test_done();
	end

	// whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge pclk);
		error_cnt++;
		$display("Error watchdog expected finish seen timeout");
		test_done();
	end
endmodule : sicr_regs_bench
